// ---- pmtc_ee_model.sv ----
// stored-copy memory answering initialization reads
`timescale 1ns/100ps
module pmtc_ee_model
  import pmtc_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_ee_addr,
  input  wire logic       i_ee_rd,
  output logic [7:0]      o_ee_data
);
  logic [7:0] a;
  initial o_ee_data = 8'h00;
  assign a = i_ee_addr;
  always @(posedge i_mclk) begin
    if (!i_ee_rd) begin
      o_ee_data <= ~o_ee_data;
    end else if (a == 8'h60) begin
      o_ee_data <= 8'h34;
    end else if (a == 8'h61) begin
      o_ee_data <= 8'h12;
    end else if (a == ADDR_SMB_ADDR) begin
      o_ee_data <= DEF_SMB_REG;
    end else if (a >= ADDR_CURR_CTRL && a < 8'h60 && a[1:0] == 2'b10) begin
      o_ee_data <= DEF_CONV[(a - ADDR_CURR_CTRL) >> 2];
    end else begin
      o_ee_data <= 8'h00;
    end
  end
endmodule // pmtc_ee_model

// ---- pmtc_pkg.sv ----
// package: register map, fields, reset values, timing for power mode control
package pmtc_pkg;
  localparam logic [7:0] ADDR_CUR_WAKE  = 8'h60;
  localparam logic [7:0] ADDR_ACC_CLR   = 8'h62;
  localparam logic [7:0] ADDR_CUR_SLEEP = 8'h64;
  localparam logic [7:0] ADDR_VP_WAKE   = 8'h68;
  localparam logic [7:0] ADDR_CELL_SLP  = 8'h6C;
  localparam logic [7:0] ADDR_STORAGE   = 8'h70;
  localparam logic [7:0] ADDR_TRIP_CTRL = 8'h76;
  localparam logic [7:0] ADDR_OP_MODE   = 8'h7A;
  localparam logic [7:0] ADDR_SMB_ADDR  = 8'h80;
  localparam logic [7:0] ADDR_CURR_CTRL = 8'h42;
  localparam logic [7:0] ADDR_CONV_STEP = 8'h04;
  localparam logic [7:0] EE_WORK_FIRST  = 8'h20;
  localparam logic [7:0] EE_WORK_LAST   = 8'h7F;
  localparam logic [7:0] EE_CAL_LAST    = 8'h84;
  // operation mode fields
  localparam int OM_SAMPLE_SLEEP_ENABLE   = 7;
  localparam int OM_DIV_HI = 5;
  localparam int OM_DIV_LO = 3;
  localparam int OM_STORE  = 2;
  localparam int OM_PORF   = 1;
  localparam int OM_SREI   = 0;
  localparam logic [7:0] OM_WMASK = 8'hBF;
  // threshold control fields
  localparam int TC_CWAKE  = 7;
  localparam int TC_CSLEEP = 6;
  localparam int TC_VPWAKE = 5;
  localparam int TC_C1SLP  = 4;
  localparam int TC_C2SLP  = 3;
  localparam int TC_STORE  = 2;
  localparam int TC_OVR    = 0;
  localparam logic [7:0] TC_WMASK = 8'hFC;
  // reset / default values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [7:0]  DEF_SMB   = 8'h16;
  localparam logic [7:0]  DEF_CONV [8] = '{8'h70, 8'h29, 8'h2A, 8'h2B,
                                          8'h24, 8'h25, 8'h76, 8'h06};
  localparam logic [7:0]  DEF_SMB_REG = {DEF_SMB[6:0], 1'b0};
  // timing
  localparam int  CLK_HZ        = 20_000_000;
  localparam real HALF_SEC_S    = 0.5;
  localparam int  HALF_SEC_CYC  = int'(HALF_SEC_S * CLK_HZ);
  localparam int  EXP_W         = 3;
  localparam int  MAG_W         = 15;

  typedef enum logic [3:0] {
    PM_RESET = 4'b0001,
    PM_INIT  = 4'b0010,
    PM_RUN   = 4'b0100,
    PM_STORE = 4'b1000
  } pmtc_state_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  sel;   // 0 current,1 pack,2 cell1,3 cell2
    logic [15:0] value;
    logic        over;
  } pmtc_result_t;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmtc_wr_t;
endpackage

// ---- pmtc_sva.sv ----
// assertion checker on the ports of pmtc_top
`timescale 1ns/100ps
module pmtc_sva
  import pmtc_pkg::*;
(
  input wire logic                   i_mclk,
  input wire logic                   i_nrst,
  input wire logic                   i_scl,
  input wire logic                   i_sda,
  input wire logic                   i_supply_ok,
  input wire pmtc_pkg::pmtc_wr_t     i_wr,
  input wire pmtc_pkg::pmtc_result_t i_result,
  input wire logic [7:0]             i_rd_addr,
  input wire logic [7:0]             o_rd_data,
  input wire logic [7:0]             o_ee_addr,
  input wire logic                   o_ee_rd,
  input wire logic [7:0]             o_accumulator_clear_bits,
  input wire logic                   o_sample_sleep,
  input wire logic                   o_low_power_osc_en,
  input wire logic                   o_storage_sleep,
  input wire logic                   o_init_busy
);
  logic wr_ok;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  assign wr_ok = i_wr.we && !o_init_busy && !o_storage_sleep;
  clr_pulse_a: assert property (wr_ok && i_wr.addr == ADDR_ACC_CLR
    |=> o_accumulator_clear_bits == $past(i_wr.wdata))
    else $error("clear bits differ from written byte");
  clr_return_a: assert property ((|o_accumulator_clear_bits)
    |=> o_accumulator_clear_bits == 8'h00
    || $past(wr_ok && i_wr.addr == ADDR_ACC_CLR))
    else $error("clear bits did not return to zero");
  sleep_write_a: assert property (wr_ok && i_wr.addr == ADDR_OP_MODE
    && !i_result.valid |=> o_sample_sleep == $past(i_wr.wdata[OM_SAMPLE_SLEEP_ENABLE]))
    else $error("sample sleep does not follow written bit");
  osc_follow_a: assert property (o_low_power_osc_en == o_sample_sleep)
    else $error("low power oscillator differs from sample sleep");
  osc_write_a: assert property (wr_ok && i_wr.addr == ADDR_OP_MODE
    && !i_result.valid
    |=> o_low_power_osc_en == $past(i_wr.wdata[OM_SAMPLE_SLEEP_ENABLE]))
    else $error("low power oscillator does not follow written bit");
  supply_low_a: assert property (!i_supply_ok [*3] |=> o_init_busy)
    else $error("supply low without reset state");
  storage_wait_a: assert property ($rose(o_storage_sleep)
    |-> $past(!i_scl && !i_sda, 3))
    else $error("storage sleep entered with lines not low");
  storage_wake_a: assert property (o_storage_sleep && i_scl && i_sda
    |-> ##[1:6] o_init_busy)
    else $error("storage sleep not left with lines high");
  ee_window_a: assert property (o_ee_rd |-> o_init_busy
    && o_ee_addr >= EE_WORK_FIRST && o_ee_addr <= EE_CAL_LAST)
    else $error("stored byte read outside initialization window");
  busy_exit_a: assert property ($fell(o_init_busy) |-> i_supply_ok)
    else $error("initialization ended with supply low");
  busy_store_a: assert property (o_init_busy |-> !o_storage_sleep)
    else $error("storage sleep during reset or initialization");
  om_rsvd_a: assert property (i_rd_addr == ADDR_OP_MODE
    |=> o_rd_data[OM_SREI] == 1'b0 && o_rd_data[6] == 1'b0)
    else $error("mode register write-only bits read nonzero");
endmodule // pmtc_sva
bind pmtc_top pmtc_sva u_pmtc_sva (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_scl(i_scl), .i_sda(i_sda), .i_supply_ok(i_supply_ok), .i_wr(i_wr),
  .i_result(i_result), .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data),
  .o_ee_addr(o_ee_addr), .o_ee_rd(o_ee_rd),
  .o_accumulator_clear_bits(o_accumulator_clear_bits),
  .o_sample_sleep(o_sample_sleep), .o_init_busy(o_init_busy),
  .o_low_power_osc_en(o_low_power_osc_en),
  .o_storage_sleep(o_storage_sleep));

// ---- pmtc_top.sv ----
// power-mode, threshold and initialization control
`timescale 1ns/100ps
module pmtc_top
  import pmtc_pkg::*;
(
  input  wire logic               i_mclk,
  input  wire logic               i_nrst,
  input  wire logic               i_supply_ok,
  input  wire logic               i_scl,
  input  wire logic               i_sda,
  input  wire logic               i_smb_stop,
  input  wire pmtc_pkg::pmtc_wr_t i_wr,
  input  wire logic [7:0]         i_rd_addr,
  output logic [7:0]              o_rd_data,
  input  wire pmtc_pkg::pmtc_result_t i_result,
  input  wire logic               i_sample_mode,
  input  wire logic [pmtc_pkg::EXP_W-1:0] i_sample_interval_exponent,
  output logic [7:0]              o_ee_addr,
  output logic                    o_ee_rd,
  input  wire logic [7:0]         i_ee_data,
  output logic [7:0]              o_accumulator_clear_bits,
  output logic                    o_sample_sleep,
  output logic                    o_low_power_osc_en,
  output logic                    o_storage_sleep,
  output logic                    o_convert_tick,
  output logic                    o_init_busy,
  output logic [7:0]              o_smb_addr,
  output logic [63:0]             o_conv_ctrl
);
  import pmtc_pkg::*;

  pmtc_state_t state_ff;
  logic [1:0]  sup_sync_ff, scl_sync_ff, sda_sync_ff;
  logic [15:0] thr_ff [5];
  logic [7:0]  acc_clr_ff, trip_ff, opm_ff, smb_ff;
  logic [7:0]  conv_ff [8];
  logic [7:0]  ee_addr_ff;
  logic        ee_wait_ff;
  logic        stop_seen_ff;
  logic [39:0] tick_cnt_ff;
  logic [7:0]  rd_ff;
  logic        host_we;
  logic        load_we;
  logic [7:0]  w_addr, w_data;
  logic        enter_ss, leave_ss, enter_store;

  // magnitude comparison, sign dropped
  function automatic logic mag_gt(input logic [15:0] a, input logic [15:0] b);
    return a[MAG_W-1:0] > b[MAG_W-1:0];
  endfunction

  // synchronise pins and supply level
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sup_sync_ff <= 2'h0;
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
    end else begin
      sup_sync_ff <= {sup_sync_ff[0], i_supply_ok};
      scl_sync_ff <= {scl_sync_ff[0], i_scl};
      sda_sync_ff <= {sda_sync_ff[0], i_sda};
    end
  end

  // power sequence
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= PM_RESET;
    end else begin
      unique case (state_ff)
        PM_RESET: begin
          if (sup_sync_ff[1]) state_ff <= PM_INIT;
        end
        PM_INIT: begin
          if (!sup_sync_ff[1]) state_ff <= PM_RESET;
          else if (ee_wait_ff && ee_addr_ff == EE_CAL_LAST)
            state_ff <= PM_RUN;
        end
        PM_RUN: begin
          if (!sup_sync_ff[1]) state_ff <= PM_RESET;
          else if (host_we && w_addr == ADDR_OP_MODE && w_data[OM_SREI])
            state_ff <= PM_INIT;
          else if (enter_store) state_ff <= PM_STORE;
        end
        PM_STORE: begin
          // volatile contents lost; wake re-initializes
          if (!sup_sync_ff[1]) state_ff <= PM_RESET;
          else if (scl_sync_ff[1] && sda_sync_ff[1]) state_ff <= PM_INIT;
        end
        default: state_ff <= PM_RESET;
      endcase
    end
  end

  // stored-copy read walk, one byte every two cycles
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ee_addr_ff <= EE_WORK_FIRST;
      ee_wait_ff <= 1'b0;
    end else if (state_ff != PM_INIT) begin
      ee_addr_ff <= EE_WORK_FIRST;
      ee_wait_ff <= 1'b0;
    end else if (!ee_wait_ff) begin
      ee_wait_ff <= 1'b1;
    end else begin
      ee_wait_ff <= 1'b0;
      ee_addr_ff <= ee_addr_ff + 8'h01;
    end
  end

  assign load_we = (state_ff == PM_INIT) && ee_wait_ff;
  assign host_we = i_wr.we && (state_ff == PM_RUN);
  assign w_addr  = load_we ? ee_addr_ff : i_wr.addr;
  assign w_data  = load_we ? i_ee_data : i_wr.wdata;

  // stop then both lines low arms storage entry
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      stop_seen_ff <= 1'b0;
    end else if (state_ff != PM_RUN) begin
      stop_seen_ff <= 1'b0;
    end else if (i_smb_stop) begin
      stop_seen_ff <= 1'b1;
    end
  end

  // trip decisions on each result update
  always_comb begin
    enter_ss = 1'b0;
    leave_ss = 1'b0;
    if (i_result.valid) begin
      unique case (i_result.sel)
        2'd0: begin
          leave_ss = trip_ff[TC_CWAKE] &&
                     mag_gt(i_result.value, thr_ff[0]);
          enter_ss = trip_ff[TC_CSLEEP] &&
                     mag_gt(thr_ff[1], i_result.value);
        end
        2'd1: begin
          leave_ss = trip_ff[TC_VPWAKE] &&
                     mag_gt(i_result.value, thr_ff[2]);
        end
        2'd2: enter_ss = trip_ff[TC_C1SLP] &&
                         mag_gt(thr_ff[3], i_result.value);
        2'd3: enter_ss = trip_ff[TC_C2SLP] &&
                         mag_gt(thr_ff[3], i_result.value);
      endcase
    end
  end

  logic store_req_ff;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      store_req_ff <= 1'b0;
    end else if (state_ff != PM_RUN) begin
      store_req_ff <= 1'b0;
    end else if (i_result.valid && i_result.sel == 2'd1 &&
                 trip_ff[TC_STORE] &&
                 mag_gt(thr_ff[4], i_result.value)) begin
      store_req_ff <= 1'b1;
    end
  end

  assign enter_store = (opm_ff[OM_STORE] || store_req_ff) && stop_seen_ff &&
                       !scl_sync_ff[1] && !sda_sync_ff[1];

  // thresholds: low byte at even offset, high byte next
  for (genvar g = 0; g < 5; g++) begin : g_thr
    localparam logic [7:0] BASE = (g == 4) ? ADDR_STORAGE :
                                  ADDR_CUR_WAKE + 8'(g * 4);
    always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
        thr_ff[g] <= RST_WORD;
      end else if (state_ff == PM_RESET) begin
        thr_ff[g] <= RST_WORD;
      end else if (host_we || load_we) begin
        if (w_addr == BASE) thr_ff[g][7:0] <= w_data;
        else if (w_addr == BASE + 8'h01) thr_ff[g][15:8] <= w_data;
      end
    end
  end

  // conversion control registers
  for (genvar c = 0; c < 8; c++) begin : g_conv
    always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
        conv_ff[c] <= DEF_CONV[c];
      end else if ((host_we || load_we) &&
                   w_addr == ADDR_CURR_CTRL + 8'(c * 4)) begin
        conv_ff[c] <= w_data;
      end
    end
    assign o_conv_ctrl[c*8 +: 8] = conv_ff[c];
  end

  // accumulator clear: pulse then self-clear
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      acc_clr_ff <= RST_BYTE;
    end else if ((host_we || load_we) && w_addr == ADDR_ACC_CLR) begin
      acc_clr_ff <= w_data;
    end else begin
      acc_clr_ff <= RST_BYTE;
    end
  end

  // threshold control; overrange set wins over host clear
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      trip_ff <= RST_BYTE;
    end else begin
      if ((host_we || load_we) && w_addr == ADDR_TRIP_CTRL)
        trip_ff <= (w_data & TC_WMASK) | (w_data & (8'h01 << TC_OVR));
      if (i_result.valid && i_result.over)
        trip_ff[TC_OVR] <= 1'b1;
    end
  end

  // operation mode
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      opm_ff <= RST_BYTE;
    end else if (state_ff == PM_RESET) begin
      opm_ff <= 8'h01 << OM_PORF;
    end else begin
      if ((host_we || load_we) && w_addr == ADDR_OP_MODE) begin
        opm_ff <= (w_data & OM_WMASK) & ~(8'h01 << OM_SREI);
        if (load_we || w_data[OM_PORF]) opm_ff[OM_PORF] <= opm_ff[OM_PORF];
      end
      if (enter_ss) opm_ff[OM_SAMPLE_SLEEP_ENABLE] <= 1'b1;
      else if (leave_ss) opm_ff[OM_SAMPLE_SLEEP_ENABLE] <= 1'b0;
    end
  end

  // slave address register
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      smb_ff <= DEF_SMB_REG;
    end else if (load_we && w_addr == ADDR_SMB_ADDR) begin
      smb_ff <= w_data;
    end
  end

  // conversion interval timer, wide enough for both exponents at seven
  logic [39:0] interval;
  always_comb begin
    interval = 40'(HALF_SEC_CYC) << i_sample_interval_exponent;
    if (opm_ff[OM_SAMPLE_SLEEP_ENABLE])
      interval = interval << opm_ff[OM_DIV_HI:OM_DIV_LO];
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      tick_cnt_ff <= 40'h0;
    end else if (state_ff != PM_RUN ||
                 !(i_sample_mode || opm_ff[OM_SAMPLE_SLEEP_ENABLE])) begin
      tick_cnt_ff <= 40'h0;
    end else if (tick_cnt_ff >= interval - 40'h1) begin
      tick_cnt_ff <= 40'h0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 40'h1;
    end
  end

  assign o_convert_tick = (state_ff == PM_RUN) &&
    (!(i_sample_mode || opm_ff[OM_SAMPLE_SLEEP_ENABLE]) || tick_cnt_ff == 40'h0);

  // register read port
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_ff <= RST_BYTE;
    end else begin
      rd_ff <= RST_BYTE;
      for (int k = 0; k < 5; k++) begin
        if (i_rd_addr == ((k == 4) ? ADDR_STORAGE : ADDR_CUR_WAKE + 8'(k * 4)))
          rd_ff <= thr_ff[k][7:0];
        if (i_rd_addr == ((k == 4) ? ADDR_STORAGE : ADDR_CUR_WAKE + 8'(k * 4))
            + 8'h01)
          rd_ff <= thr_ff[k][15:8];
      end
      for (int k = 0; k < 8; k++)
        if (i_rd_addr == ADDR_CURR_CTRL + 8'(k * 4)) rd_ff <= conv_ff[k];
      if (i_rd_addr == ADDR_ACC_CLR)   rd_ff <= acc_clr_ff;
      if (i_rd_addr == ADDR_TRIP_CTRL) rd_ff <= trip_ff;
      if (i_rd_addr == ADDR_OP_MODE)   rd_ff <= opm_ff;
      if (i_rd_addr == ADDR_SMB_ADDR)  rd_ff <= smb_ff;
    end
  end

  assign o_rd_data                = rd_ff;
  assign o_ee_addr                = ee_addr_ff;
  assign o_ee_rd                  = (state_ff == PM_INIT) && !ee_wait_ff;
  assign o_accumulator_clear_bits = acc_clr_ff;
  assign o_sample_sleep           = opm_ff[OM_SAMPLE_SLEEP_ENABLE];
  assign o_low_power_osc_en       = opm_ff[OM_SAMPLE_SLEEP_ENABLE];
  assign o_storage_sleep          = (state_ff == PM_STORE);
  assign o_init_busy              = (state_ff != PM_RUN) &&
                                    (state_ff != PM_STORE);
  assign o_smb_addr               = smb_ff;
endmodule // pmtc_top

// ---- pmtc_top_tb.sv ----
// self-checking bench for power mode trip control
`timescale 1ns/100ps
module pmtc_top_tb;
  import pmtc_pkg::*;
  logic         i_mclk, i_nrst, i_supply_ok, i_scl, i_sda, i_smb_stop;
  logic         i_sample_mode, scl_run, scl_lvl, o_ee_rd, o_sample_sleep;
  logic         o_low_power_osc_en, o_storage_sleep, o_init_busy;
  logic         o_convert_tick;
  logic [2:0]   i_sample_interval_exponent;
  logic [1:0]   scl_cnt = 2'h0;
  pmtc_wr_t     i_wr;
  pmtc_result_t i_result;
  logic [7:0]   i_rd_addr, o_rd_data, o_ee_addr, i_ee_data, o_smb_addr;
  logic [7:0]   o_accumulator_clear_bits;
  logic [63:0]  o_conv_ctrl;
  logic [15:0]  v;
  int           failures, num_checks;
  logic [7:0]   th [5] = '{8'h60, 8'h64, 8'h68, 8'h6C, 8'h70};
  logic [7:0]   t_tc [6] = '{8'h40, 8'h80, 8'h20, 8'h10, 8'h08, 8'h00};
  logic [7:0]   t_ad [6] = '{8'h64, 8'h60, 8'h68, 8'h6C, 8'h6C, 8'h60};
  logic [15:0]  t_th [6] = '{16'h8100, 16'h0200, 16'h1000, 16'h0800,
                              16'h0800, 16'h0200};
  logic [1:0]   t_sl [6] = '{2'd0, 2'd0, 2'd1, 2'd2, 2'd3, 2'd0};
  logic [15:0]  t_rv [6] = '{16'h80FF, 16'h8201, 16'h1001, 16'h87FF,
                              16'h07FF, 16'h8201};
  logic         t_pr [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  logic         t_ex [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  pmtc_top u_pmtc_top (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_supply_ok(i_supply_ok), .i_scl(i_scl), .i_sda(i_sda),
    .i_smb_stop(i_smb_stop), .i_wr(i_wr), .i_rd_addr(i_rd_addr),
    .o_rd_data(o_rd_data), .i_result(i_result),
    .i_sample_mode(i_sample_mode), .o_ee_addr(o_ee_addr),
    .i_sample_interval_exponent(i_sample_interval_exponent),
    .o_ee_rd(o_ee_rd), .i_ee_data(i_ee_data),
    .o_accumulator_clear_bits(o_accumulator_clear_bits),
    .o_sample_sleep(o_sample_sleep), .o_storage_sleep(o_storage_sleep),
    .o_low_power_osc_en(o_low_power_osc_en),
    .o_convert_tick(o_convert_tick),
    .o_init_busy(o_init_busy), .o_smb_addr(o_smb_addr),
    .o_conv_ctrl(o_conv_ctrl));
  pmtc_ee_model u_pmtc_ee_model (.i_mclk(i_mclk), .i_ee_addr(o_ee_addr),
    .i_ee_rd(o_ee_rd), .o_ee_data(i_ee_data));
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  // link clock toggles every fourth edge, 400 ns period
  always @(posedge i_mclk) begin
    scl_cnt <= scl_cnt + 2'h1;
    if (scl_cnt == 2'h3 || !i_nrst) i_scl <= scl_run ? ~i_scl : scl_lvl;
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_mclk) i_wr <= '{1'b1, a, d};
    @(posedge i_mclk) i_wr <= '0;
    #1;
  endtask
  task automatic wr16(logic [7:0] a, logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 8'h01, d[15:8]);
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge i_mclk) i_rd_addr <= a;
    tick();
    v = {8'h00, o_rd_data};
  endtask
  task automatic rd16(logic [7:0] a);
    rd(a + 8'h01);
    v[15:8] = v[7:0];
    @(posedge i_mclk) i_rd_addr <= a;
    tick();
    v[7:0] = o_rd_data;
  endtask
  task automatic res(logic [1:0] s, logic [15:0] val, logic ov);
    @(posedge i_mclk) i_result <= '{1'b1, s, val, ov};
    @(posedge i_mclk) i_result <= '0;
  endtask
  function automatic logic pick(int w);
    return w == 0 ? o_sample_sleep : w == 1 ? o_storage_sleep : o_init_busy;
  endfunction
  task automatic waitfor(int w, logic e, int lim);
    for (int n = 0; n < lim && pick(w) !== e; n++) tick();
    chk("wait", pick(w), e);
    if (pick(w) !== e) finish_test();
  endtask
  initial begin
    i_nrst = 1'b0; i_supply_ok = 1'b0; scl_run = 1'b0; scl_lvl = 1'b1;
    i_sda = 1'b1; i_smb_stop = 1'b0; i_sample_mode = 1'b0;
    i_sample_interval_exponent = 3'h0;
    i_wr = '0; i_rd_addr = 8'h00; i_result = '0;
    failures = 0; num_checks = 0;
    tick(2);
    for (int c = 0; c < 8; c++) chk("conv", o_conv_ctrl[c*8 +: 8], DEF_CONV[c]);
    chk("smb", o_smb_addr, {7'h16, 1'b0});
    chk("sample_sleep_enable", o_sample_sleep, 1'b0);
    @(posedge i_mclk) i_nrst <= 1'b1;
    tick(10);
    chk("busy", o_init_busy, 1'b1);
    rd(ADDR_OP_MODE);
    chk("por", v, 16'h0002);
    @(posedge i_mclk) i_supply_ok <= 1'b1;
    scl_run = 1'b1;
    waitfor(2, 1'b0, 1000);
    chk("smb", o_smb_addr, {7'h16, 1'b0});
    chk("tick", o_convert_tick, 1'b1);
    @(posedge i_mclk) i_sample_mode <= 1'b1;
    tick(3);
    chk("tick", o_convert_tick, 1'b0);
    @(posedge i_mclk) i_sample_mode <= 1'b0;
    tick();
    chk("tick", o_convert_tick, 1'b1);
    rd16(8'h60);
    chk("load", v, 16'h1234);
    rd16(ADDR_VP_WAKE);
    chk("thr", v, 16'h0000);
    wr(ADDR_OP_MODE, 8'h02);
    rd(ADDR_OP_MODE);
    chk("por", v[1], 1'b1);
    wr(ADDR_OP_MODE, 8'h00);
    rd(ADDR_OP_MODE);
    chk("por", v[1], 1'b0);
    rd(8'h7B);
    chk("unmapped", v, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_ACC_CLR, k ? 8'h5A : 8'hA5);
      chk("clr", o_accumulator_clear_bits, k ? 8'h5A : 8'hA5);
      tick();
      chk("clr", o_accumulator_clear_bits, 8'h00);
    end
    rd(ADDR_ACC_CLR);
    chk("clrreg", v, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      wr16(th[i], {th[i], 8'hC3});
      rd16(th[i]);
      chk("thr", v, {th[i], 8'hC3});
    end
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_OP_MODE, {t_pr[i], 7'h00});
      chk("osc", o_low_power_osc_en, t_pr[i]);
      wr16(t_ad[i], t_th[i]);
      wr(ADDR_TRIP_CTRL, t_tc[i]);
      res(t_sl[i], t_rv[i], 1'b0);
      waitfor(0, t_ex[i], 20);
      tick(5);
      chk("sample_sleep_enable", o_sample_sleep, t_ex[i]);
    end
    res(2'd0, 16'h0001, 1'b1);
    rd(ADDR_TRIP_CTRL);
    chk("ovr", v[0], 1'b1);
    wr(ADDR_TRIP_CTRL, 8'h00);
    rd(ADDR_TRIP_CTRL);
    chk("ovr", v[0], 1'b0);
    wr(ADDR_OP_MODE, 8'h04);
    scl_run = 1'b0;
    scl_lvl = 1'b0;
    @(posedge i_mclk) i_sda <= 1'b0;
    tick(20);
    chk("early", o_storage_sleep, 1'b0);
    @(posedge i_mclk) i_smb_stop <= 1'b1;
    @(posedge i_mclk) i_smb_stop <= 1'b0;
    waitfor(1, 1'b1, 20);
    scl_lvl = 1'b1;
    @(posedge i_mclk) i_sda <= 1'b1;
    waitfor(2, 1'b1, 20);
    waitfor(2, 1'b0, 1000);
    scl_run = 1'b1;
    wr16(8'h60, 16'h0000);
    wr(ADDR_OP_MODE, 8'h01);
    waitfor(2, 1'b1, 10);
    waitfor(2, 1'b0, 1000);
    rd16(8'h60);
    chk("reinit", v, 16'h1234);
    finish_test();
  end
endmodule // pmtc_top_tb
